/* rtl/dspcg_pkg.sv */
// package: offsets, field positions, reset values and types of the deep-sleep clock gate
package dspcg_pkg;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam logic [11:0] DSPCG_OFF_GATE1   = 12'h124;  // deep_sleep_periph_clock_gate_1
  localparam logic [11:0] DSPCG_OFF_MODE    = 12'h200;  // power mode and auto gating control
  localparam logic [11:0] DSPCG_OFF_STATUS  = 12'h204;  // effective enables and fault status
  localparam logic [31:0] DSPCG_GATE1_RESET = 32'h00000000;
  localparam logic [31:0] DSPCG_GATE1_MASK  = 32'h00071013;
  localparam logic [31:0] DSPCG_MODE_RESET  = 32'h00000000;

  // ==========================================================================
  // unit numbering and gate bit positions
  // ==========================================================================
  localparam int DSPCG_UNITS = 7;
  localparam int DSPCG_BIT_GP_C   = 16;
  localparam int DSPCG_BIT_GP_B   = 17;
  localparam int DSPCG_BIT_GP_A   = 18;
  localparam int DSPCG_BIT_TW0    = 12;
  localparam int DSPCG_BIT_SS0    = 4;
  localparam int DSPCG_BIT_AS1    = 1;
  localparam int DSPCG_BIT_AS0    = 0;

  // mode register fields
  localparam int DSPCG_MODE_DEEP_BIT = 0;   // system is in deep-sleep
  localparam int DSPCG_MODE_SLEEP_BIT = 1;  // system is in sleep
  localparam int DSPCG_MODE_ACG_BIT  = 2;   // auto_clock_gating_enable

  // status register fields
  localparam int DSPCG_STAT_FAULT_BIT = 31; // sticky bus fault seen

  // ==========================================================================
  // types
  // ==========================================================================
  typedef logic [DSPCG_UNITS-1:0] dspcg_units_t;

  typedef enum logic [2:0] {
    DSPCG_RUN   = 3'b001,
    DSPCG_SLEEP = 3'b010,
    DSPCG_DEEP  = 3'b100
  } dspcg_mode_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } dspcg_req_s;

  typedef struct packed {
    logic         valid;
    dspcg_units_t unit_sel;
  } dspcg_pacc_s;

endpackage : dspcg_pkg

/* rtl/dspcg_top.sv */
// deep-sleep peripheral clock gate register, per-unit clock gates and gated-access fault check
//
// Function
// - the gate register sits at offset 0x124 and holds one enable bit per controlled unit.
// - a set gate bit lets the clock reach its unit.
// - a clear gate bit withholds that unit's clock, leaving it disabled.
// - an access to a unit whose clock is gated off raises a bus fault instead of completing.
// - after reset the register reads all zeros so every unit is unclocked in deep-sleep until its bit is set.
// - bits 18, 17 and 16 gate general-purpose timers 2, 1 and 0.
// - bit 12 gates the two-wire module 0.
// - bit 4 gates the synchronous serial module 0.
// - bits 1 and 0 gate asynchronous serial modules 1 and 0.
// - reserved bits are read-only zero and software writes back what it read.
// - this register governs clocks in deep-sleep while run and sleep have their own registers.
// - sleep-mode gating registers apply only while automatic clock gating is enabled.
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
module dspcg_top (
  input  wire logic                        CLOCK,          // system clock, 10 MHz
  input  wire logic                        RESET,          // synchronous reset, active high
  input  wire logic [11:0]                 REG_ADDR,       // register byte address
  input  wire logic [31:0]                 REG_WDATA,      // register write data
  input  wire logic                        REG_WR,         // write strobe
  input  wire logic                        REG_RD,         // read strobe
  output logic      [31:0]                 REG_RDATA,      // read data, cycle after strobe
  input  wire dspcg_pkg::dspcg_units_t     RUN_GATE,       // run-mode enables from run register
  input  wire dspcg_pkg::dspcg_units_t     SLEEP_GATE,     // sleep-mode enables from sleep register
  input  wire dspcg_pkg::dspcg_pacc_s      PERIPH_ACC,     // peripheral access request from fabric
  output logic                             PERIPH_FAULT,   // bus fault, cycle after access
  output logic                             PERIPH_OK,      // access may complete, cycle after access
  output dspcg_pkg::dspcg_units_t          UNIT_CLK_EN,    // effective per-unit enables
  output dspcg_pkg::dspcg_units_t          UNIT_CLK        // gated per-unit clocks
);

  // ==========================================================================
  // register state
  // ==========================================================================
  logic [31:0]              gate_q;
  logic [31:0]              mode_q;
  logic                     fault_seen_q;
  logic [31:0]              rdata_q;
  dspcg_pkg::dspcg_units_t  en_q;
  dspcg_pkg::dspcg_units_t  en_d;
  dspcg_pkg::dspcg_mode_e   pmode;
  dspcg_pkg::dspcg_req_s    req;
  logic                     fault_q;
  logic                     ok_q;
  logic                     fault_now;

  assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};

  // ==========================================================================
  // decoding between gate register bits and unit vectors
  // ==========================================================================
  function automatic dspcg_pkg::dspcg_units_t units_of(input logic [31:0] r);
    units_of = {r[dspcg_pkg::DSPCG_BIT_GP_A], r[dspcg_pkg::DSPCG_BIT_GP_B],
                r[dspcg_pkg::DSPCG_BIT_GP_C], r[dspcg_pkg::DSPCG_BIT_TW0],
                r[dspcg_pkg::DSPCG_BIT_SS0], r[dspcg_pkg::DSPCG_BIT_AS1],
                r[dspcg_pkg::DSPCG_BIT_AS0]};
  endfunction : units_of

  function automatic logic [31:0] bits_of(input dspcg_pkg::dspcg_units_t u);
    logic [31:0] r;
    r = 32'h00000000;
    r[dspcg_pkg::DSPCG_BIT_GP_A] = u[6];
    r[dspcg_pkg::DSPCG_BIT_GP_B] = u[5];
    r[dspcg_pkg::DSPCG_BIT_GP_C] = u[4];
    r[dspcg_pkg::DSPCG_BIT_TW0]  = u[3];
    r[dspcg_pkg::DSPCG_BIT_SS0]  = u[2];
    r[dspcg_pkg::DSPCG_BIT_AS1]  = u[1];
    r[dspcg_pkg::DSPCG_BIT_AS0]  = u[0];
    bits_of = r;
  endfunction : bits_of

  // ==========================================================================
  // register writes
  // ==========================================================================
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      gate_q <= dspcg_pkg::DSPCG_GATE1_RESET;
    end else if (req.wr && req.addr == dspcg_pkg::DSPCG_OFF_GATE1) begin
      gate_q <= req.wdata & dspcg_pkg::DSPCG_GATE1_MASK;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      mode_q <= dspcg_pkg::DSPCG_MODE_RESET;
    end else if (req.wr && req.addr == dspcg_pkg::DSPCG_OFF_MODE) begin
      mode_q <= {29'h00000000, req.wdata[2:0]};
    end
  end

  // ==========================================================================
  // power mode select: deep wins over sleep
  // ==========================================================================
  always_comb begin
    if (mode_q[dspcg_pkg::DSPCG_MODE_DEEP_BIT]) begin
      pmode = dspcg_pkg::DSPCG_DEEP;
    end else if (mode_q[dspcg_pkg::DSPCG_MODE_SLEEP_BIT]) begin
      pmode = dspcg_pkg::DSPCG_SLEEP;
    end else begin
      pmode = dspcg_pkg::DSPCG_RUN;
    end
  end

  always_comb begin
    case (pmode)
      dspcg_pkg::DSPCG_DEEP: begin
        en_d = units_of(gate_q);
      end
      dspcg_pkg::DSPCG_SLEEP: begin
        if (mode_q[dspcg_pkg::DSPCG_MODE_ACG_BIT]) begin
          en_d = SLEEP_GATE;
        end else begin
          en_d = RUN_GATE;
        end
      end
      default: begin
        en_d = RUN_GATE;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      en_q <= '0;
    end else begin
      en_q <= en_d;
    end
  end

  assign UNIT_CLK_EN = en_q;

  // ==========================================================================
  // per-unit clock gates
  // ==========================================================================
  genvar g;
  generate
    for (g = 0; g < dspcg_pkg::DSPCG_UNITS; g++) begin : g_gate
      dspcg_unit_gate u_gate (
        .clk_in  (CLOCK),
        .enable  (en_q[g]),
        .clk_out (UNIT_CLK[g])
      );
    end
  endgenerate

  // ==========================================================================
  // access check for gated units
  // ==========================================================================
  assign fault_now = PERIPH_ACC.valid && ((PERIPH_ACC.unit_sel & ~en_q) != '0);

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      fault_q <= 1'b0;
      ok_q    <= 1'b0;
    end else begin
      fault_q <= fault_now;
      ok_q    <= PERIPH_ACC.valid && !fault_now;
    end
  end

  assign PERIPH_FAULT = fault_q;
  assign PERIPH_OK    = ok_q;

  // sticky fault: a new fault wins over a clear in the same cycle
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      fault_seen_q <= 1'b0;
    end else if (fault_now) begin
      fault_seen_q <= 1'b1;
    end else if (req.wr && req.addr == dspcg_pkg::DSPCG_OFF_STATUS
                 && req.wdata[dspcg_pkg::DSPCG_STAT_FAULT_BIT]) begin
      fault_seen_q <= 1'b0;
    end
  end

  // ==========================================================================
  // read data, one cycle after the strobe
  // ==========================================================================
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      rdata_q <= 32'h00000000;
    end else if (req.rd) begin
      case (req.addr)
        dspcg_pkg::DSPCG_OFF_GATE1:  rdata_q <= gate_q;
        dspcg_pkg::DSPCG_OFF_MODE:   rdata_q <= mode_q;
        dspcg_pkg::DSPCG_OFF_STATUS: rdata_q <= bits_of(en_q)
                                                | {fault_seen_q, 31'h00000000};
        default:                     rdata_q <= 32'h00000000;
      endcase
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign REG_RDATA = rdata_q;

endmodule : dspcg_top

/* rtl/dspcg_unit_gate.sv */
// one glitch-free clock gate: enable latched while the clock is low
`timescale 1ns/100ps
module dspcg_unit_gate (
  input  wire logic clk_in,   // source clock
  input  wire logic enable,   // gate enable
  output logic      clk_out   // gated clock
);

  logic en_lat;

  // latch transparent while clock low keeps the output free of glitches
  always_latch begin
    if (!clk_in) begin
      en_lat <= enable;
    end
  end

  assign clk_out = clk_in & en_lat;

endmodule : dspcg_unit_gate

/* sim/dspcg_periph_model.sv */
// peripheral-side model: each gated unit counts the clock edges it receives
`timescale 1ns/100ps
module dspcg_periph_model (
  input  wire dspcg_pkg::dspcg_units_t unit_clk, // gated clocks
  output wire logic [6:0][7:0]         ticks     // edges seen per unit
);
  for (genvar i = 0; i < 7; i++) begin : g_unit
    logic [7:0] cnt = 8'h00;
    always @(posedge unit_clk[i]) cnt <= cnt + 8'h01;
    assign ticks[i] = cnt;
  end
endmodule : dspcg_periph_model

/* sim/dspcg_top_assertions.sv */
// checker: register, enable and fault relations at the gate block's ports
`timescale 1ns/100ps
module dspcg_top_assertions (
  input wire logic                    CLOCK,        // clock
  input wire logic                    RESET,        // reset
  input wire logic [11:0]             REG_ADDR,     // addr
  input wire logic [31:0]             REG_WDATA,    // wdata
  input wire logic                    REG_WR,       // write
  input wire logic                    REG_RD,       // read
  input wire logic [31:0]             REG_RDATA,    // rdata
  input wire dspcg_pkg::dspcg_units_t RUN_GATE,     // run en
  input wire dspcg_pkg::dspcg_units_t SLEEP_GATE,   // sleep en
  input wire dspcg_pkg::dspcg_pacc_s  PERIPH_ACC,   // access
  input wire logic                    PERIPH_FAULT, // fault
  input wire logic                    PERIPH_OK,    // ok
  input wire dspcg_pkg::dspcg_units_t UNIT_CLK_EN,  // enables
  input wire dspcg_pkg::dspcg_units_t UNIT_CLK      // clocks
);
  logic [31:0]             gate_q;
  logic [2:0]              mode_q;
  logic                    up_q;
  dspcg_pkg::dspcg_units_t exp_en;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  // ==========================================================================
  // shadow of gate and mode registers
  // ==========================================================================
  always_ff @(posedge CLOCK) begin
    up_q <= !RESET;
    if (RESET) begin
      gate_q <= 32'h00000000;
      mode_q <= 3'h0;
    end else if (REG_WR && REG_ADDR == dspcg_pkg::DSPCG_OFF_GATE1) begin
      gate_q <= REG_WDATA & dspcg_pkg::DSPCG_GATE1_MASK;
    end else if (REG_WR && REG_ADDR == dspcg_pkg::DSPCG_OFF_MODE) begin
      mode_q <= REG_WDATA[2:0];
    end
  end
  always_comb begin
    if (mode_q[0]) exp_en = {gate_q[18:16], gate_q[12], gate_q[4], gate_q[1:0]};
    else if (mode_q[1] && mode_q[2]) exp_en = SLEEP_GATE;
    else exp_en = RUN_GATE;
  end
  sequence s_gate_wr;
    REG_WR && REG_ADDR == dspcg_pkg::DSPCG_OFF_GATE1;
  endsequence
  sequence s_gate_rd;
    REG_RD && REG_ADDR == dspcg_pkg::DSPCG_OFF_GATE1;
  endsequence
  // ==========================================================================
  // assertions
  // ==========================================================================
  a_gate_readback:
    assert property (s_gate_wr ##1 !REG_WR ##1 s_gate_rd |=> REG_RDATA == ($past(REG_WDATA, 3) & 32'h00071013))
    else $error("gate register read back wrong");
  a_reserved_zero:
    assert property (s_gate_rd |=> (REG_RDATA & 32'hFFF8EFEC) == 32'h00000000) else $error("reserved bit set");
  a_reset_clear:
    assert property ($past(RESET) |-> UNIT_CLK_EN == 7'h00 && REG_RDATA == 32'h00000000) else $error("not clear");
  a_enable_follows:
    assert property (up_q |-> UNIT_CLK_EN == $past(exp_en)) else $error("unit enables wrong");
  a_fault_gated:
    assert property (PERIPH_ACC.valid && |(PERIPH_ACC.unit_sel & ~UNIT_CLK_EN) |=> PERIPH_FAULT && !PERIPH_OK)
    else $error("no fault on gated unit");
  a_ok_enabled:
    assert property (PERIPH_ACC.valid && (PERIPH_ACC.unit_sel & ~UNIT_CLK_EN) == 7'h00 |=> PERIPH_OK && !PERIPH_FAULT)
    else $error("enabled access refused");
  a_idle_quiet:
    assert property (!PERIPH_ACC.valid |=> !PERIPH_FAULT && !PERIPH_OK) else $error("response without access");
  a_rdata_quiet:
    assert property (!REG_RD |=> REG_RDATA == 32'h00000000) else $error("read data without read");
endmodule : dspcg_top_assertions

bind dspcg_top dspcg_top_assertions u_chk (.CLOCK(CLOCK), .RESET(RESET), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RUN_GATE(RUN_GATE),
  .SLEEP_GATE(SLEEP_GATE), .PERIPH_ACC(PERIPH_ACC), .PERIPH_FAULT(PERIPH_FAULT), .PERIPH_OK(PERIPH_OK),
  .UNIT_CLK_EN(UNIT_CLK_EN), .UNIT_CLK(UNIT_CLK));

/* sim/test_dspcg_top.sv */
// testbench: register access, mode selection, gating and fault checks of the deep-sleep clock gate
`timescale 1ns/100ps
module test_dspcg_top;
  logic                    clk, rst, wr, rd, fault, ok, rd_pend, acc_pend;
  logic [11:0]             addr;
  logic [31:0]             wdata, rdata, v;
  dspcg_pkg::dspcg_units_t run_g, slp_g, en, uclk, exp_en;
  dspcg_pkg::dspcg_pacc_s  acc;
  logic [6:0][7:0]         ticks, t0;
  logic [31:0]             rd_exp[$];
  logic [1:0]              acc_exp[$];
  int                      bad_count, n_compared, cyc;
  int                      bitpos[7] = '{0, 1, 4, 12, 16, 17, 18};
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  dspcg_top u_dut (.CLOCK(clk), .RESET(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .RUN_GATE(run_g), .SLEEP_GATE(slp_g), .PERIPH_ACC(acc), .PERIPH_FAULT(fault),
    .PERIPH_OK(ok), .UNIT_CLK_EN(en), .UNIT_CLK(uclk));
  dspcg_periph_model u_model (.unit_clk(uclk), .ticks(ticks));
  // ==========================================================================
  // bus tasks, compares, monitor
  // ==========================================================================
  task automatic chk_rdata(input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL read data expected %h seen %h", e, s);
    end
  endtask : chk_rdata
  task automatic chk_resp(input logic [1:0] e, input logic [1:0] s);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL fault ok expected %b seen %b", e, s);
    end
  endtask : chk_resp
  task automatic chk_clk(input int u, input logic e, input logic s);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL unit clock %0d expected %b seen %b", u, e, s);
    end
  endtask : chk_clk
  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    rd_exp.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rreg
  task automatic sweep();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      acc <= '{1'b1, (i == 7) ? 7'h7F : 7'(1 << i)};
      acc_exp.push_back((((i == 7) ? 7'h7F : 7'(1 << i)) & ~exp_en) != 0 ? 2'b10 : 2'b01);
    end
    @(posedge clk);
    acc <= '0;
  endtask : sweep
  task automatic setm(input logic [2:0] m, input dspcg_pkg::dspcg_units_t e);
    wreg(dspcg_pkg::DSPCG_OFF_MODE, {29'h0, m});
    exp_en = e;
    repeat (2) @(posedge clk);
  endtask : setm
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    rd_pend <= rd;
    acc_pend <= acc.valid;
    cyc++;
    if (rd_pend) chk_rdata(rd_exp.pop_front(), rdata);
    if (acc_pend) chk_resp(acc_exp.pop_front(), {fault, ok});
    if (cyc == 3000) bad_count++;
    if (cyc == 3000) complete_run();
  end
  // ==========================================================================
  // scenarios
  // ==========================================================================
  initial begin
    {wr, rd, addr, wdata, acc} <= '0;
    exp_en = '0;
    rst <= 1'b1;
    void'($urandom(67));
    run_g <= 7'($urandom);
    slp_g <= 7'($urandom);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rreg(12'h124, 32'h00000000);
    rreg(12'h3F0, 32'h00000000);
    exp_en = run_g;
    for (int k = 0; k < 5; k++) begin
      v = (k == 4) ? 32'hFFFFFFFF : $urandom;
      wreg(12'h124, v);
      rreg(12'h124, v & 32'h00071013);
    end
    sweep();
    setm(3'h2, run_g);
    sweep();
    setm(3'h6, slp_g);
    sweep();
    setm(3'h1, 7'h7F);
    sweep();
    for (int i = 0; i < 7; i++) begin
      wreg(12'h124, 32'h1 << bitpos[i]);
      exp_en = 7'(1 << i);
      repeat (2) @(posedge clk);
      t0 = ticks;
      repeat (5) @(posedge clk);
      for (int j = 0; j < 7; j++) chk_clk(j, exp_en[j], ticks[j] != t0[j]);
      sweep();
    end
    rreg(12'h200, 32'h00000001);
    rreg(12'h204, 32'h80040000);
    wreg(12'h204, 32'h80000000);
    rreg(12'h204, 32'h00040000);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    exp_en = run_g;
    rreg(12'h124, 32'h00000000);
    sweep();
    repeat (3) @(posedge clk);
    complete_run();
  end
endmodule : test_dspcg_top
